// ==== verilog/flm_fault_monitor.sv ====
// fault supervision, flags, halted code latch and led voltage converter control
// Functional notes
// - supply monitor enable bit0, threshold bits 2:1
// - trip forces torch or shutdown per config
// - restore needs supply recovered and flags read
// - supply must stay low 250 us
// - ramp monitor enable bit3, threshold bits 5:4
// - ramp trip freezes current at reached step
// - first two flash codes ignored by monitor
// - ramp monitor needs 8 us low
// - halted codes latched, channel two high nibble
// - ramp steps torch then flash, 32 us
// - 4-bit result of higher led voltage
// - bit5 powers converter down, resets zero
// - sample delay 250 us to 8 ms
// - done falls auto at target, manual read/rewrite
// - eight flags, cleared by flags read
// - timeout flag bit0, cleared read or reset
// - thermal deglitch 250 us, off until read
// - led open 2 us, short 250 us fault
// - led fault clears only when fault gone
// - sync inputs flag active edges by polarity
// - thermistor flag, resume after read and recovery
// - flag bit6 ramp trip, read before resume; code restarts the ramp on the next flash without a read
// - flag bit7 supply monitor trip

`include "flm_defines.svh"

// ****************************************
// synchroniser plus continuous-level deglitch
// ****************************************
module flm_deglitch #(
  parameter int COUNT = 1
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic async_in,  // raw comparator level
  input  wire logic active,    // qualifier, drops count when low
  output logic      level      // high once held for COUNT cycles
);
  localparam int CW = $clog2(COUNT + 1);
  logic          sync1_reg;    // first stage, read only by sync2_reg
  logic          sync2_reg;
  logic [CW-1:0] cnt_reg;      // cycles the level has stood

  // two-stage synchroniser
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  // any gap in the level restarts the count, so short dips never trip
  always_ff @(posedge clk_sys) begin
    if (rst || !active || !sync2_reg) begin
      cnt_reg <= '0;
      level   <= 1'b0;
    end else if (cnt_reg == CW'(COUNT - 1)) begin
      level   <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

// ****************************************
// top level
// ****************************************
module flm_fault_monitor import flm_pkg::*; #(
  parameter int SUPPLY_CYC  = `FLM_US2CYC(`FLM_T_SUPPLY_US),
  parameter int SHORT_CYC   = `FLM_US2CYC(`FLM_T_SHORT_US),
  parameter int THERMAL_CYC = `FLM_US2CYC(`FLM_T_THERMAL_US),
  parameter int ADC_STEP_CYC = `FLM_US2CYC(`FLM_T_ADC_STEP_US)
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,              // hardware enable low
  // register port from the control interface front end
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // mode control, same clock
  input  wire logic       mode_flash,
  input  wire logic       mode_torch,
  input  wire logic       mode_privacy,
  input  wire logic       flash_start,      // pulse: ramp begins
  input  wire logic       flash_timer_expired, // pulse: timeout hit
  input  wire flm_code_t  led1_target,
  input  wire flm_code_t  led2_target,
  input  wire logic       supply_trip_to_off,  // 1 shutdown, 0 torch
  input  wire logic       sync1_mode,
  input  wire logic       sync2_mode,
  input  wire logic       sync1_pol_high,
  input  wire logic       sync2_pol_high,
  input  wire logic       thermistor_mode,
  // analog comparators and converter, asynchronous
  input  wire logic       supply_below_trip,
  input  wire logic       supply_below_ramp_trip,
  input  wire logic       output_overvoltage_trip,
  input  wire logic       led_pin_below_short,
  input  wire logic       overtemp,
  input  wire logic       thermistor_below_trip,
  input  wire logic       rf_sync_input_one,
  input  wire logic       rf_sync_input_two,
  input  wire flm_code_t  adc_value,        // max of the two led voltages
  // outputs to the current sources and converter
  output logic            force_torch,
  output logic            force_off,
  output flm_code_t       led1_code,
  output flm_code_t       led2_code,
  output logic            ramp_torch_phase,
  output logic            ramp_at_target,
  output logic            adc_enable,
  output logic            adc_sample
);
  localparam int STEP_CYC     = `FLM_US2CYC(`FLM_T_STEP_US);
  localparam int RAMP_MON_CYC = `FLM_US2CYC(`FLM_T_RAMP_MON_US);
  localparam int OPEN_CYC     = `FLM_NS2CYC(`FLM_T_OPEN_NS);
  localparam int SW  = $clog2(STEP_CYC + 1);
  localparam int AW  = $clog2(ADC_STEP_CYC + 1);

  // ****************************************
  // registers and state
  // ****************************************
  logic [7:0] supply_cfg_reg;      // supply_monitor_config
  logic [7:0] halted_code_reg;     // halted_flash_code
  logic [5:4] vmon_ctl_reg;        // manual mode and power-down
  flm_code_t  vmon_result_reg;     // converter result
  logic       eoc_reg;             // conversion done
  logic [4:0] adc_delay_reg;       // converter_sample_delay, steps minus one
  logic [7:0] flags_reg;           // fault_event_flags
  logic [7:0] flags_next;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  flm_ramp_e  ramp_state_reg;
  logic [SW-1:0] step_cnt_reg;     // cycles within one ramp step
  flm_code_t  fstep_reg;           // ramp step index
  logic       supply_wait_read_reg; // trip seen, waiting for flags read
  logic       thermal_off_reg;
  logic       ntc_hold_reg;
  logic       ntc_wait_read_reg;
  flm_adc_e   adc_state_reg;
  logic [4:0] adc_steps_reg;
  logic [AW-1:0] adc_cnt_reg;
  logic       sync1_prev_reg;
  logic       sync2_prev_reg;
  // deglitched levels
  logic supply_low;
  logic supply_low_now;
  logic ramp_low;
  logic open_hit;
  logic short_hit;
  logic tsd_hit;
  logic ntc_low;
  logic tx1_lvl;
  logic tx2_lvl;
  flm_code_t adc_sync;
  logic flags_read;
  logic vmon_read;
  logic led_active;
  logic ramp_mon_armed;
  logic ramp_trip;

  assign flags_read = reg_rd && (reg_addr == `FLM_OFS_FLAGS);
  assign vmon_read  = reg_rd && (reg_addr == `FLM_OFS_LED_VMON);
  assign led_active = mode_flash || mode_torch || mode_privacy;

  // ****************************************
  // synchronised comparators and deglitch timers
  // ****************************************
  flm_deglitch #(.COUNT(SUPPLY_CYC)) u_supply (
    .clk_sys(clk_sys), .rst(rst), .async_in(supply_below_trip),
    .active(supply_cfg_reg[`FLM_SUP_EN_BIT]), .level(supply_low));
  // undelayed copy, used only to see the supply come back
  flm_deglitch #(.COUNT(1)) u_supply_now (
    .clk_sys(clk_sys), .rst(rst), .async_in(supply_below_trip),
    .active(1'b1), .level(supply_low_now));
  // armed only while climbing and past the first two flash codes
  assign ramp_mon_armed = supply_cfg_reg[`FLM_RAMP_EN_BIT] &&
                          (ramp_state_reg == FLM_RAMP_FLASH) &&
                          (fstep_reg >= `FLM_RAMP_IGNORE);
  flm_deglitch #(.COUNT(RAMP_MON_CYC)) u_ramp (
    .clk_sys(clk_sys), .rst(rst), .async_in(supply_below_ramp_trip),
    .active(ramp_mon_armed), .level(ramp_low));
  flm_deglitch #(.COUNT(OPEN_CYC)) u_open (
    .clk_sys(clk_sys), .rst(rst), .async_in(output_overvoltage_trip),
    .active(led_active), .level(open_hit));
  flm_deglitch #(.COUNT(SHORT_CYC)) u_short (
    .clk_sys(clk_sys), .rst(rst), .async_in(led_pin_below_short),
    .active(led_active), .level(short_hit));
  flm_deglitch #(.COUNT(THERMAL_CYC)) u_tsd (
    .clk_sys(clk_sys), .rst(rst), .async_in(overtemp),
    .active(1'b1), .level(tsd_hit));
  flm_deglitch #(.COUNT(1)) u_ntc (
    .clk_sys(clk_sys), .rst(rst), .async_in(thermistor_below_trip),
    .active(1'b1), .level(ntc_low));
  flm_deglitch #(.COUNT(1)) u_tx1 (
    .clk_sys(clk_sys), .rst(rst), .async_in(rf_sync_input_one),
    .active(1'b1), .level(tx1_lvl));
  flm_deglitch #(.COUNT(1)) u_tx2 (
    .clk_sys(clk_sys), .rst(rst), .async_in(rf_sync_input_two),
    .active(1'b1), .level(tx2_lvl));
  // converter bits pass a synchroniser each; sampled only after settling
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_adc
    flm_deglitch #(.COUNT(1)) u_adc (
      .clk_sys(clk_sys), .rst(rst), .async_in(adc_value[gi]),
      .active(1'b1), .level(adc_sync[gi]));
  end

  assign ramp_trip = ramp_low && (ramp_state_reg == FLM_RAMP_FLASH);

  // ****************************************
  // flash turn-on ramp
  // ****************************************
  // one shared step index; each channel stops at its own target
  always_ff @(posedge clk_sys) begin
    if (rst || !mode_flash) begin
      ramp_state_reg <= FLM_RAMP_IDLE;
      step_cnt_reg   <= '0;
      fstep_reg      <= '0;
    end else begin
      case (ramp_state_reg)
        FLM_RAMP_IDLE: begin
          if (flash_start) begin
            ramp_state_reg <= FLM_RAMP_TORCH;
            step_cnt_reg   <= '0;
            fstep_reg      <= '0;
          end
        end
        FLM_RAMP_TORCH, FLM_RAMP_FLASH: begin
          if (ramp_trip) begin
            ramp_state_reg <= FLM_RAMP_HOLD;
          end else if (step_cnt_reg == SW'(STEP_CYC - 1)) begin
            step_cnt_reg <= '0;
            if (ramp_state_reg == FLM_RAMP_TORCH) begin
              // torch codes run out, flash codes start from zero
              if (fstep_reg == `FLM_TORCH_STEPS) begin
                ramp_state_reg <= FLM_RAMP_FLASH;
                fstep_reg      <= '0;
              end else begin
                fstep_reg <= fstep_reg + 1'b1;
              end
            end else if (fstep_reg >= led1_target && fstep_reg >= led2_target) begin
              ramp_state_reg <= FLM_RAMP_HOLD;
            end else begin
              fstep_reg <= fstep_reg + 1'b1;
            end
          end else begin
            step_cnt_reg <= step_cnt_reg + 1'b1;
          end
        end
        FLM_RAMP_HOLD: begin
          step_cnt_reg <= '0;                                          // frozen level
        end
        default: begin
          ramp_state_reg <= FLM_RAMP_IDLE;
        end
      endcase
    end
  end

  // channel codes follow the ramp, clipped at each target
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      led1_code        <= '0;
      led2_code        <= '0;
      ramp_torch_phase <= 1'b0;
      ramp_at_target   <= 1'b0;
    end else begin
      led1_code        <= (fstep_reg > led1_target) ? led1_target : fstep_reg;
      led2_code        <= (fstep_reg > led2_target) ? led2_target : fstep_reg;
      ramp_torch_phase <= (ramp_state_reg == FLM_RAMP_TORCH);
      ramp_at_target   <= (ramp_state_reg == FLM_RAMP_HOLD);
    end
  end

  // halted codes, channel one low nibble
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      halted_code_reg <= 8'h00;
    end else if (ramp_trip) begin
      halted_code_reg <= {led2_code, led1_code};
    end
  end

  // ****************************************
  // protective holds on the current sources
  // ****************************************
  // supply trip holds until the supply recovers and the flags were read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      force_torch          <= 1'b0;
      force_off            <= 1'b0;
      supply_wait_read_reg <= 1'b0;
    end else if (supply_low) begin
      force_torch          <= !supply_trip_to_off;
      force_off            <= supply_trip_to_off || thermal_off_reg || ntc_hold_reg;
      supply_wait_read_reg <= 1'b1;
    end else begin
      if (flags_read) begin
        supply_wait_read_reg <= 1'b0;
      end
      // release only once both conditions have been met
      if (!supply_wait_read_reg && !supply_low_now) begin
        force_torch <= 1'b0;
        force_off   <= thermal_off_reg || ntc_hold_reg;
      end else begin
        force_off   <= force_off || thermal_off_reg || ntc_hold_reg;
      end
    end
  end

  // thermal and thermistor shutdown; a read once overtemp has cleared releases thermal
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      thermal_off_reg   <= 1'b0;
      ntc_hold_reg      <= 1'b0;
      ntc_wait_read_reg <= 1'b0;
    end else begin
      if (tsd_hit) begin
        thermal_off_reg <= 1'b1;
      end else if (flags_read) begin
        thermal_off_reg <= 1'b0;
      end
      if (flag_set[`FLM_FLG_THERMISTOR]) begin
        ntc_hold_reg      <= 1'b1;
        ntc_wait_read_reg <= 1'b1;
      end else begin
        if (flags_read) begin
          ntc_wait_read_reg <= 1'b0;
        end
        if (!ntc_wait_read_reg && !ntc_low) begin
          ntc_hold_reg <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // flags register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_prev_reg <= 1'b0;
      sync2_prev_reg <= 1'b0;
    end else begin
      sync1_prev_reg <= tx1_lvl;
      sync2_prev_reg <= tx2_lvl;
    end
  end

  always_comb begin
    flag_set = 8'h00;
    flag_set[`FLM_FLG_TIMEOUT]    = mode_flash && flash_timer_expired;
    flag_set[`FLM_FLG_THERMAL]    = tsd_hit;
    flag_set[`FLM_FLG_LED_FAULT]  = open_hit || short_hit;
    flag_set[`FLM_FLG_SYNC1]      = sync1_mode && (tx1_lvl != sync1_prev_reg) &&
                                    (tx1_lvl == sync1_pol_high);
    flag_set[`FLM_FLG_SYNC2]      = sync2_mode && (tx2_lvl != sync2_prev_reg) &&
                                    (tx2_lvl == sync2_pol_high);
    flag_set[`FLM_FLG_THERMISTOR] = thermistor_mode && ntc_low &&
                                    (mode_flash || mode_torch);
    flag_set[`FLM_FLG_RAMP_MON]   = ramp_trip;
    flag_set[`FLM_FLG_SUPPLY_MON] = supply_low;
    // a read clears all bits except those set in the same cycle, which win; the led fault only once it is gone
    flag_clr = flags_read ? 8'hff : 8'h00;
    flag_clr[`FLM_FLG_LED_FAULT] = flags_read && !open_hit && !short_hit;
    flags_next = (flags_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ****************************************
  // writable registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      supply_cfg_reg <= `FLM_RST_SUPPLY_CFG;
      vmon_ctl_reg   <= 2'(`FLM_RST_LED_VMON >> 4);
      adc_delay_reg  <= 5'(`FLM_RST_ADC_DELAY);
    end else if (reg_wr) begin
      case (reg_addr)
        `FLM_OFS_SUPPLY_CFG: supply_cfg_reg <= {2'b00, reg_wdata[5:0]};
        `FLM_OFS_LED_VMON:   vmon_ctl_reg   <= reg_wdata[5:4];
        `FLM_OFS_ADC_DELAY:  adc_delay_reg  <= reg_wdata[4:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // led voltage converter sequencer
  // ****************************************
  // done falls on target reached (auto), or on read / manual rewrite
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      adc_state_reg   <= FLM_ADC_DONE;
      eoc_reg         <= 1'b1;
      adc_steps_reg   <= '0;
      adc_cnt_reg     <= '0;
      vmon_result_reg <= '0;
      adc_sample      <= 1'b0;
      adc_enable      <= 1'b0;
    end else begin
      adc_enable <= !vmon_ctl_reg[`FLM_VMON_PDN_BIT];
      adc_sample <= 1'b0;
      case (adc_state_reg)
        FLM_ADC_DONE: begin
          if (!vmon_ctl_reg[`FLM_VMON_PDN_BIT] &&
              ((!vmon_ctl_reg[`FLM_VMON_MANUAL_BIT] && ramp_state_reg == FLM_RAMP_FLASH &&
                fstep_reg >= led1_target && fstep_reg >= led2_target &&
                step_cnt_reg == SW'(STEP_CYC - 1)) ||
               (vmon_ctl_reg[`FLM_VMON_MANUAL_BIT] && vmon_read) ||
               (reg_wr && reg_addr == `FLM_OFS_LED_VMON &&
                reg_wdata[`FLM_VMON_MANUAL_BIT]))) begin
            eoc_reg       <= 1'b0;
            adc_state_reg <= FLM_ADC_WAIT;
            adc_steps_reg <= '0;
            adc_cnt_reg   <= '0;
          end
        end
        FLM_ADC_WAIT: begin
          // delay is (field + 1) steps of 250 us
          if (adc_cnt_reg == AW'(ADC_STEP_CYC - 1)) begin
            adc_cnt_reg <= '0;
            if (adc_steps_reg == adc_delay_reg) begin
              adc_state_reg <= FLM_ADC_SAMPLE;
              adc_sample    <= 1'b1;
            end else begin
              adc_steps_reg <= adc_steps_reg + 1'b1;
            end
          end else begin
            adc_cnt_reg <= adc_cnt_reg + 1'b1;
          end
        end
        FLM_ADC_SAMPLE: begin
          vmon_result_reg <= adc_sync;
          eoc_reg         <= 1'b1;
          adc_state_reg   <= FLM_ADC_DONE;
        end
        default: begin
          adc_state_reg <= FLM_ADC_DONE;
        end
      endcase
    end
  end

  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FLM_OFS_SUPPLY_CFG:  reg_rdata <= supply_cfg_reg;
        `FLM_OFS_HALTED_CODE: reg_rdata <= halted_code_reg;
        `FLM_OFS_LED_VMON:    reg_rdata <= {eoc_reg, 1'b0, vmon_ctl_reg, vmon_result_reg};
        `FLM_OFS_ADC_DELAY:   reg_rdata <= {3'b000, adc_delay_reg};
        `FLM_OFS_FLAGS:       reg_rdata <= flags_reg;
        default:              reg_rdata <= 8'h00;                      // unmapped
      endcase
    end
  end
endmodule

// ==== include/flm_defines.svh ====
// constants of the flash led fault monitor: offsets, fields, resets, timing
`ifndef FLM_DEFINES_SVH
`define FLM_DEFINES_SVH

// ****************************************
// clock and timing
// ****************************************
`define FLM_CLK_KHZ          40000
`define FLM_T_SUPPLY_US      250
`define FLM_T_RAMP_MON_US    8
`define FLM_T_OPEN_NS        2000
`define FLM_T_SHORT_US       250
`define FLM_T_THERMAL_US     250
`define FLM_T_STEP_US        32
`define FLM_T_ADC_STEP_US    250
// cycle counts, rounded up to whole cycles, never below one
`define FLM_US2CYC(t)        ((((t) * `FLM_CLK_KHZ) + 999) / 1000)
`define FLM_NS2CYC(t)        ((((t) * `FLM_CLK_KHZ) + 999999) / 1000000)

// ****************************************
// register offsets
// ****************************************
`define FLM_OFS_SUPPLY_CFG   8'h00
`define FLM_OFS_HALTED_CODE  8'h01
`define FLM_OFS_LED_VMON     8'h02
`define FLM_OFS_ADC_DELAY    8'h03
`define FLM_OFS_FLAGS        8'h04

// ****************************************
// field positions and resets
// ****************************************
`define FLM_SUP_EN_BIT       0
`define FLM_RAMP_EN_BIT      3
`define FLM_VMON_MANUAL_BIT  4
`define FLM_VMON_PDN_BIT     5
`define FLM_VMON_EOC_BIT     7
`define FLM_FLG_TIMEOUT      0
`define FLM_FLG_THERMAL      1
`define FLM_FLG_LED_FAULT    2
`define FLM_FLG_SYNC1        3
`define FLM_FLG_SYNC2        4
`define FLM_FLG_THERMISTOR   5
`define FLM_FLG_RAMP_MON     6
`define FLM_FLG_SUPPLY_MON   7
`define FLM_RST_SUPPLY_CFG   8'h00
`define FLM_RST_LED_VMON     8'h00
`define FLM_RST_ADC_DELAY    8'h00
`define FLM_TORCH_STEPS      4'h7
`define FLM_RAMP_IGNORE      4'h2

`endif

// ==== include/flm_pkg.sv ====
// types shared by the flash led fault monitor
package flm_pkg;
  // ramp phases of the flash turn-on
  typedef enum logic [1:0] {
    FLM_RAMP_IDLE,
    FLM_RAMP_TORCH,
    FLM_RAMP_FLASH,
    FLM_RAMP_HOLD
  } flm_ramp_e;
  // converter delay sequencer
  typedef enum logic [1:0] {
    FLM_ADC_DONE,
    FLM_ADC_WAIT,
    FLM_ADC_SAMPLE
  } flm_adc_e;
  typedef logic [3:0] flm_code_t;
endpackage

// ==== bench/flm_host_model.sv ====
// host model driving the register port of the fault monitor
module flm_host_model (
  input  wire logic [7:0] reg_rdata,
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // one strobe cycle, address and data held until the sampling edge
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// ==== bench/flm_fault_monitor_monitor.sv ====
// port checker for the fault monitor
module flm_fault_monitor_monitor import flm_pkg::*; #(
  parameter int SUPPLY_CYC = 1
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       mode_flash,
  input wire logic       flash_start,
  input wire logic       supply_trip_to_off,
  input wire logic       supply_below_trip,
  input wire logic       supply_below_ramp_trip,
  input wire flm_code_t  led1_target,
  input wire logic       force_torch,
  input wire flm_code_t  led1_code,
  input wire flm_code_t  led2_code,
  input wire logic       ramp_torch_phase,
  input wire logic       ramp_at_target,
  input wire logic       adc_enable,
  input wire logic       adc_sample
);
  timeunit 1ns;
  timeprecision 100ps;
  int scnt;  // raw cycles with supply low
  int rcnt;  // raw cycles below ramp level
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys) scnt <= supply_below_trip ? scnt + 1 : 0;
  always_ff @(posedge clk_sys) rcnt <= supply_below_ramp_trip ? rcnt + 1 : 0;
  chk_trip_mode_torch: assert property ($rose(force_torch) |-> !supply_trip_to_off)
    else $error("torch forced in off setting");
  chk_supply_deglitch: assert property ($rose(force_torch) |-> scnt >= SUPPLY_CYC)
    else $error("supply trip too early");
  chk_supply_hold: assert property (force_torch && supply_below_trip |=> force_torch)
    else $error("torch released with supply low");
  chk_ramp_freeze: assert property (ramp_at_target && mode_flash && !flash_start |=> $stable({led2_code, led1_code}))
    else $error("frozen code moved");
  chk_ramp_clip: assert property (mode_flash && !ramp_torch_phase |-> led1_code <= led1_target)
    else $error("code above target");
  chk_halt_deglitch: assert property ($rose(ramp_at_target) && led1_code != led1_target |-> rcnt >= 320 && led1_code >= 4'h2)
    else $error("ramp halted early");
  chk_pdn_ctrl: assert property ($past(reg_wr, 2) && $past(reg_addr, 2) == 8'h02 |-> adc_enable == !$past(reg_wdata[5], 2))
    else $error("converter power state wrong");
  chk_sample_enabled: assert property (adc_sample |-> adc_enable && !$past(adc_sample))
    else $error("bad sample pulse");
endmodule
bind flm_fault_monitor flm_fault_monitor_monitor #(.SUPPLY_CYC(SUPPLY_CYC)) u_chk (.*);

// ==== bench/flm_fault_monitor_tb_top.sv ====
// bench for the flash led fault monitor
module flm_fault_monitor_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SC = 20;  // shortened counts keep the run short
  logic clk_sys = 0, rst = 1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, force_torch, force_off, ramp_torch_phase, ramp_at_target, adc_enable, adc_sample;
  logic [3:0] led1_code, led2_code, led1_target = 0, led2_target = 0, adc_value = 4'ha;
  logic mode_flash = 0, mode_torch = 0, mode_privacy = 0, flash_start = 0, flash_timer_expired = 0;
  logic supply_trip_to_off = 0, sync1_mode = 0, sync2_mode = 0, sync1_pol_high = 0, sync2_pol_high = 0;
  logic thermistor_mode = 0, supply_below_trip = 0, supply_below_ramp_trip = 0, overtemp = 0;
  logic output_overvoltage_trip = 0, led_pin_below_short = 0, thermistor_below_trip = 0;
  logic rf_sync_input_one = 0, rf_sync_input_two = 0;
  int fails = 0, tests_run = 0, n;
  flm_fault_monitor #(.SUPPLY_CYC(SC), .SHORT_CYC(SC), .THERMAL_CYC(SC), .ADC_STEP_CYC(SC)) dut (.*);
  flm_host_model host (.*);
  always #12.5 clk_sys = ~clk_sys;
  task automatic print_verdict();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // bounded wait: 0 for ramp frozen, 1 for sample pulse
  task automatic wt(input bit s);
    for (n = 0; (s ? adc_sample : ramp_at_target) !== 1'b1; n++) begin
      if (n > 20000) begin
        fails++;
        print_verdict();
      end
      cyc(1);
    end
  endtask
  initial begin
    cyc(6);
    rst <= 0;
    rc(8'h02, 8'h80);
    rc(8'h09, 8'h00);
    host.wr(8'h00, 8'hff);
    host.wr(8'h01, 8'h55);
    rc(8'h00, 8'h3f);
    rc(8'h01, 8'h00);
    mode_torch <= 1;
    supply_below_trip <= 1;
    cyc(SC - 5);
    supply_below_trip <= 0;
    cyc(5);
    rc(8'h04, 8'h00);
    supply_below_trip <= 1;
    cyc(SC + 8);
    chk({7'h00, force_torch}, 8'h01);
    rc(8'h04, 8'h80);
    chk({7'h00, force_torch}, 8'h01);
    supply_below_trip <= 0;
    cyc(6);
    // a read while still tripped does not count, so the hold stays
    chk({7'h00, force_torch}, 8'h01);
    rc(8'h04, 8'h80);
    cyc(2);
    chk({7'h00, force_torch}, 8'h00);
    rc(8'h04, 8'h00);
    {supply_trip_to_off, supply_below_trip} <= 2'h3;
    cyc(SC + 8);
    chk({7'h00, force_off}, 8'h01);
    supply_below_trip <= 0;
    cyc(4);
    rc(8'h04, 8'h80);
    cyc(2);
    chk({7'h00, force_off}, 8'h00);
    overtemp <= 1;
    cyc(SC + 8);
    overtemp <= 0;
    cyc(6);
    chk({7'h00, force_off}, 8'h01);
    rc(8'h04, 8'h02);
    cyc(3);
    chk({7'h00, force_off}, 8'h00);
    {sync1_mode, sync2_mode, sync1_pol_high} <= 3'h7;
    cyc(4);
    {rf_sync_input_one, rf_sync_input_two} <= 2'h3;
    cyc(6);
    rc(8'h04, 8'h08);
    {rf_sync_input_one, rf_sync_input_two} <= 2'h0;
    cyc(6);
    rc(8'h04, 8'h10);
    {thermistor_mode, thermistor_below_trip} <= 2'h3;
    cyc(6);
    chk({7'h00, force_off}, 8'h01);
    thermistor_below_trip <= 0;
    cyc(4);
    chk({7'h00, force_off}, 8'h01);
    rc(8'h04, 8'h20);
    cyc(3);
    chk({7'h00, force_off}, 8'h00);
    {mode_torch, mode_flash, led1_target, led2_target, supply_below_ramp_trip} <= 11'h3ff;
    cyc(2);
    flash_start <= 1;
    cyc(1);
    flash_start <= 0;
    cyc(2);
    chk({7'h00, ramp_torch_phase}, 8'h01);
    wt(0);
    rc(8'h01, 8'h22);
    chk({led2_code, led1_code}, 8'h22);
    flash_timer_expired <= 1;
    cyc(1);
    {flash_timer_expired, output_overvoltage_trip} <= 2'h1;
    cyc(90);
    rc(8'h04, 8'h45);
    output_overvoltage_trip <= 0;
    cyc(5);
    rc(8'h04, 8'h04);
    rc(8'h04, 8'h00);
    mode_flash <= 0;
    host.wr(8'h03, 8'h01);
    host.wr(8'h02, 8'h10);
    wt(1);
    chk({7'h00, n >= 37 && n <= 44}, 8'h01);
    cyc(2);
    rc(8'h02, 8'h9a);
    host.wr(8'h02, 8'h20);
    cyc(2);
    chk({7'h00, adc_enable}, 8'h00);
    print_verdict();
  end
endmodule
